// ==== include/cicie_pkg.sv ====
// package: register map, field positions, reset values for the interrupt enable control block
package cicie_pkg;
  localparam logic [7:0] CICIE_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CICIE_ADDR_STATUS = 8'h01;
  localparam logic [7:0] CICIE_ADDR_MASK = 8'h02;
  localparam int CICIE_BIT_RESET_REQ = 0;
  localparam int CICIE_BIT_RX = 1;
  localparam int CICIE_BIT_TX = 2;
  localparam int CICIE_BIT_ERR = 3;
  localparam int CICIE_BIT_OVR = 4;
  localparam int CICIE_BIT_ONE = 5;
  localparam int CICIE_BIT_COMPAT = 6;
  localparam int CICIE_BIT_ZERO = 7;
  localparam logic [7:0] CICIE_CTRL_RESET = 8'h01;
  localparam logic [3:0] CICIE_EVT_RESET = 4'h0;
  localparam logic [3:0] CICIE_MASK_RESET = 4'hf;
  localparam logic [7:0] CICIE_UNMAPPED = 8'h00;
  localparam int CICIE_NUM_EVT = 4;
endpackage

// ==== include/cicie_evt_if.sv ====
// interface: event pulses and gating enables between the top and the event latch
`timescale 1ns/1ns
interface cicie_evt_if;
  logic [3:0] pulse;
  logic [3:0] enable;
  logic [3:0] clear;
  logic [3:0] sticky;
  modport ctrl (output pulse, output enable, output clear, input sticky);
  modport latch (input pulse, input enable, input clear, output sticky);
endinterface

// ==== core/cicie_evt_latch.sv ====
// module: sticky event bits, one per interrupt source
`timescale 1ns/1ns
module cicie_evt_latch (
  input wire logic clk_in,
  input wire logic reset_in,
  cicie_evt_if.latch evt
);
  import cicie_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < CICIE_NUM_EVT; gi++) begin : g_evt
      logic sticky_ff;
      // set wins over clear so a same-cycle event is never lost
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          sticky_ff <= 1'b0;
        end else if (evt.pulse[gi] && evt.enable[gi]) begin
          sticky_ff <= 1'b1;
        end else if (evt.clear[gi]) begin
          sticky_ff <= 1'b0;
        end
      end
      assign evt.sticky[gi] = sticky_ff;
    end
  endgenerate
endmodule // cicie_evt_latch

// ==== core/cicie_top.sv ====
// module: interrupt enable control register with gated interrupt output
`timescale 1ns/1ns
module cicie_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic overrun_in,
  input wire logic err_change_in,
  input wire logic tx_done_in,
  input wire logic rx_ok_in,
  input wire logic bus_off_in,
  output logic reset_mode_out,
  output logic abort_frame_out,
  output logic irq_out
);
  import cicie_pkg::*;

  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [3:0] mask_ff;
  logic [7:0] rdata_ff;
  logic reset_mode_q_ff;
  logic [7:0] ctrl_view;
  cicie_evt_if evt ();

  ////////////////////////////////////////////////////////////////////////
  // control register; bit 0 forced on by bus-off, bit 7 not stored
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_in && addr_in == CICIE_ADDR_CTRL) begin
      nxt_ctrl = wdata_in;
      nxt_ctrl[CICIE_BIT_ZERO] = 1'b0;
    end
    if (bus_off_in) begin
      nxt_ctrl[CICIE_BIT_RESET_REQ] = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_ff <= CICIE_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // mask register, 1 lets a latched event reach irq_out
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mask_ff <= CICIE_MASK_RESET;
    end else if (wr_in && addr_in == CICIE_ADDR_MASK) begin
      mask_ff <= wdata_in[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event order in the latch: rx, tx, err, overrun at bits 0..3
  assign evt.pulse = {overrun_in, err_change_in, tx_done_in, rx_ok_in};
  assign evt.enable = {ctrl_ff[CICIE_BIT_OVR], ctrl_ff[CICIE_BIT_ERR],
                       ctrl_ff[CICIE_BIT_TX], ctrl_ff[CICIE_BIT_RX]};
  assign evt.clear = (wr_in && addr_in == CICIE_ADDR_STATUS) ? wdata_in[3:0] : 4'h0;

  cicie_evt_latch u_latch (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .evt(evt)
  );

  // level interrupt while any unmasked sticky bit is set
  assign irq_out = |(evt.sticky & mask_ff);

  ////////////////////////////////////////////////////////////////////////
  // reset mode and a one-cycle abort on entry
  assign reset_mode_out = ctrl_ff[CICIE_BIT_RESET_REQ];
  // follower starts at one so leaving reset never fakes an abort
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      reset_mode_q_ff <= 1'b1;
    end else begin
      reset_mode_q_ff <= ctrl_ff[CICIE_BIT_RESET_REQ];
    end
  end
  assign abort_frame_out = ctrl_ff[CICIE_BIT_RESET_REQ] && !reset_mode_q_ff;

  ////////////////////////////////////////////////////////////////////////
  // read path, data valid the cycle after rd_in
  // idle cycles return zero so stale data never looks like a fresh answer
  always_comb begin
    ctrl_view = ctrl_ff;
    ctrl_view[CICIE_BIT_ONE] = 1'b1;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_ff <= CICIE_UNMAPPED;
    end else if (rd_in) begin
      case (addr_in)
        CICIE_ADDR_CTRL: rdata_ff <= ctrl_view;
        CICIE_ADDR_STATUS: rdata_ff <= {4'h0, evt.sticky};
        CICIE_ADDR_MASK: rdata_ff <= {4'h0, mask_ff};
        default: rdata_ff <= CICIE_UNMAPPED;
      endcase
    end else begin
      rdata_ff <= CICIE_UNMAPPED;
    end
  end
  assign rdata_out = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // assertions; each label line names the behaviour it guards
  // all run on clk_in and stand down while reset_in is high

  // readback shows the register as it stood at the strobe; bus-off may move it later
  a_ctrl_readback: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_in && addr_in == CICIE_ADDR_CTRL |=> rdata_out == $past(ctrl_view))
    else $error("ctrl readback wrong");

  // enabled overrun latches on the next edge
  a_ovr_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    overrun_in && ctrl_ff[CICIE_BIT_OVR] |=> evt.sticky[3])
    else $error("overrun not latched");

  // overrun with its enable low never reaches the latch
  a_ovr_block: assert property (@(posedge clk_in) disable iff (reset_in)
    !evt.sticky[3] && !(overrun_in && ctrl_ff[CICIE_BIT_OVR]) |=> !evt.sticky[3])
    else $error("overrun latched while disabled");

  // enabled error or bus status change latches on the next edge
  a_err_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    err_change_in && ctrl_ff[CICIE_BIT_ERR] |=> evt.sticky[2])
    else $error("error not latched");

  // error change with its enable low never reaches the latch
  a_err_block: assert property (@(posedge clk_in) disable iff (reset_in)
    !evt.sticky[2] && !(err_change_in && ctrl_ff[CICIE_BIT_ERR]) |=> !evt.sticky[2])
    else $error("error latched while disabled");

  // enabled transmit done latches on the next edge
  a_tx_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    tx_done_in && ctrl_ff[CICIE_BIT_TX] |=> evt.sticky[1])
    else $error("tx not latched");

  // transmit done with its enable low never reaches the latch
  a_tx_block: assert property (@(posedge clk_in) disable iff (reset_in)
    !evt.sticky[1] && !(tx_done_in && ctrl_ff[CICIE_BIT_TX]) |=> !evt.sticky[1])
    else $error("tx latched while disabled");

  // enabled clean receive latches on the next edge
  a_rx_gate: assert property (@(posedge clk_in) disable iff (reset_in)
    rx_ok_in && ctrl_ff[CICIE_BIT_RX] |=> evt.sticky[0])
    else $error("rx not latched");

  // receive with its enable low never reaches the latch
  a_rx_block: assert property (@(posedge clk_in) disable iff (reset_in)
    !evt.sticky[0] && !(rx_ok_in && ctrl_ff[CICIE_BIT_RX]) |=> !evt.sticky[0])
    else $error("rx latched while disabled");

  // reserved bit 5 always reads back as one
  a_bit5_one: assert property (@(posedge clk_in) disable iff (reset_in)
    rd_in && addr_in == CICIE_ADDR_CTRL |=> rdata_out[CICIE_BIT_ONE])
    else $error("bit 5 read zero");

  // reserved bit 7 never holds a one
  a_bit7_zero: assert property (@(posedge clk_in) disable iff (reset_in)
    !ctrl_ff[CICIE_BIT_ZERO])
    else $error("bit 7 stored one");

  // bus-off forces reset mode on the next edge, over any host write
  a_busoff_reset: assert property (@(posedge clk_in) disable iff (reset_in)
    bus_off_in |=> reset_mode_out)
    else $error("bus-off missed reset mode");

  // clearing the request bit returns to operating mode unless bus-off holds it
  a_leave_reset: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_in && addr_in == CICIE_ADDR_CTRL && !wdata_in[CICIE_BIT_RESET_REQ] && !bus_off_in |=> !reset_mode_out)
    else $error("reset mode not left");

  // every entry into reset mode by host write or bus-off aborts the frame in flight
  a_abort_entry: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(reset_mode_out) |-> abort_frame_out)
    else $error("abort missing on reset mode entry");

  // abort is a single-cycle pulse
  a_abort_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
    abort_frame_out |=> !abort_frame_out)
    else $error("abort longer than one cycle");

  // clearing every status bit with no event pending drops the interrupt
  a_irq_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    wr_in && addr_in == CICIE_ADDR_STATUS && wdata_in[3:0] == 4'hf && (evt.pulse & evt.enable) == 4'h0
    |=> !irq_out) else $error("irq stayed after clear");

  // a fully closed mask keeps the interrupt low
  a_irq_masked: assert property (@(posedge clk_in) disable iff (reset_in)
    mask_ff == 4'h0 |-> !irq_out)
    else $error("irq high while masked");

  // read data is zero outside the answer cycle
  a_rdata_idle: assert property (@(posedge clk_in) disable iff (reset_in)
    !rd_in |=> rdata_out == CICIE_UNMAPPED)
    else $error("read data outside answer cycle");

  // main scenarios the bench should reach
  c_irq_rise: cover property (@(posedge clk_in) disable iff (reset_in) $rose(irq_out));
  c_leave_reset: cover property (@(posedge clk_in) disable iff (reset_in) $fell(reset_mode_out));
  c_abort: cover property (@(posedge clk_in) disable iff (reset_in) abort_frame_out);
  c_set_clear: cover property (@(posedge clk_in) disable iff (reset_in)
    rx_ok_in && evt.clear[0] && ctrl_ff[CICIE_BIT_RX]);
  c_bus_off: cover property (@(posedge clk_in) disable iff (reset_in) bus_off_in && !reset_mode_out);
endmodule // cicie_top

// ==== test/cicie_host.sv ====
// host model: byte-wide register master for the interrupt enable control block
`timescale 1ns/1ns
module cicie_host (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [7:0] rdata_in
);
  import cicie_pkg::*;
  // bus idle at time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one-cycle write; released lines show the inverse so stale values never match
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= (a == CICIE_ADDR_CTRL) ? (d & 8'h7f) : d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  // one-cycle read; data taken in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule // cicie_host

// ==== test/can_control_interrupt_enables_tb.sv ====
// testbench: reset values, enable/event table, then mask, reserved bits, mode, bus-off and mid-run reset cases
`timescale 1ns/1ns
module can_control_interrupt_enables_tb;
  import cicie_pkg::*;
  typedef struct {logic [7:0] ctrl; logic [3:0] ev; logic irq; logic [3:0] sts;} cicie_row_t;
  logic clk_in, reset_in, bus_off, wr, rd, reset_mode, abort, irq;
  logic [3:0] ev;
  logic [7:0] addr, wdata, rdata, rd_val;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  // each event alone, once with its own enable and once with all others enabled
  cicie_row_t rows [8] = '{'{8'h02, 4'h1, 1'b1, 4'h1}, '{8'h04, 4'h2, 1'b1, 4'h2}, '{8'h08, 4'h4, 1'b1, 4'h4},
    '{8'h10, 4'h8, 1'b1, 4'h8}, '{8'h1c, 4'h1, 1'b0, 4'h0}, '{8'h1a, 4'h2, 1'b0, 4'h0},
    '{8'h16, 4'h4, 1'b0, 4'h0}, '{8'h0e, 4'h8, 1'b0, 4'h0}};
  cicie_top i_dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .overrun_in(ev[3]), .err_change_in(ev[2]), .tx_done_in(ev[1]),
    .rx_ok_in(ev[0]), .bus_off_in(bus_off), .reset_mode_out(reset_mode), .abort_frame_out(abort), .irq_out(irq));
  cicie_host i_host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // hang guard: whole run needs well under 500 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle event pulse, then wait for the latch edge to settle
  task automatic fire(input logic [3:0] e);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= 4'h0;
    @(negedge clk_in);
  endtask
  task automatic print_verdict();
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_in = 1'b1;
    ev = 4'h0;
    bus_off = 1'b0;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    i_host.read_reg(CICIE_ADDR_CTRL, rd_val);
    check8(rd_val, 8'h21);
    check8({7'h00, reset_mode}, 8'h01);
    i_host.read_reg(CICIE_ADDR_MASK, rd_val);
    check8(rd_val, 8'h0f);
    for (int i = 0; i < 8; i++) begin
      i_host.write_reg(CICIE_ADDR_CTRL, rows[i].ctrl);
      fire(rows[i].ev);
      check8({7'h00, irq}, {7'h00, rows[i].irq});
      i_host.read_reg(CICIE_ADDR_STATUS, rd_val);
      check8(rd_val, {4'h0, rows[i].sts});
      i_host.write_reg(CICIE_ADDR_STATUS, 8'h0f);
      @(negedge clk_in);
      check8({7'h00, irq}, 8'h00);
    end
    // masked event stays latched but silent until unmasked
    i_host.write_reg(CICIE_ADDR_MASK, 8'h00);
    fire(4'h2);
    check8({7'h00, irq}, 8'h00);
    i_host.write_reg(CICIE_ADDR_MASK, 8'h0f);
    @(negedge clk_in);
    check8({7'h00, irq}, 8'h01);
    i_host.write_reg(CICIE_ADDR_CTRL, 8'hc0);
    i_host.read_reg(CICIE_ADDR_CTRL, rd_val);
    check8(rd_val, 8'h60);
    i_host.write_reg(CICIE_ADDR_CTRL, 8'h01);
    @(negedge clk_in);
    check8({6'h00, abort, reset_mode}, 8'h03);
    @(negedge clk_in);
    check8({6'h00, abort, reset_mode}, 8'h01);
    i_host.write_reg(CICIE_ADDR_CTRL, 8'h00);
    @(negedge clk_in);
    check8({7'h00, reset_mode}, 8'h00);
    @(posedge clk_in);
    bus_off <= 1'b1;
    @(posedge clk_in);
    bus_off <= 1'b0;
    @(negedge clk_in);
    check8({6'h00, abort, reset_mode}, 8'h03);
    i_host.read_reg(8'h05, rd_val);
    check8(rd_val, 8'h00);
    check8({7'h00, irq}, 8'h01);
    // mid-run reset drops the pending interrupt and restores every register
    @(posedge clk_in);
    reset_in <= 1'b1;
    @(negedge clk_in);
    check8({5'h00, irq, abort, reset_mode}, 8'h01);
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    i_host.read_reg(CICIE_ADDR_CTRL, rd_val);
    check8(rd_val, 8'h21);
    i_host.read_reg(CICIE_ADDR_STATUS, rd_val);
    check8(rd_val, 8'h00);
    i_host.read_reg(CICIE_ADDR_MASK, rd_val);
    check8(rd_val, 8'h0f);
    print_verdict();
  end
endmodule // can_control_interrupt_enables_tb
